// ==== rtl/nvm_ctrl_map.vh ====
// Register addresses, bit positions, unlock values, masks and timing counts of the NVM access controller.
// Assumes a core special-function-register bus with 9-bit addresses and 8-bit data.
// How it works
// - With store_permit clear, no write cycle to either space can start.
// - Write trigger starts a cycle; hardware clears it; software only sets.
// - Finishing a write cycle sets store_done_flag.
// - Data write erases byte at nvm_addr_low then programs nvm_data_low; core runs.
// - Program write stalls core, erases and programs high:low word, flags, resumes.
// - External or watchdog reset during a write sets aborted_store_flag.
// - External and watchdog resets keep address, data and space_select.
// - space_select one means program memory, zero means data memory.
// - space_select writes are ignored while a read or write runs.
// - Read trigger starts a read; hardware clears it; software only sets.
// - Data read byte lands in nvm_data_low the next cycle.
// - nvm_data_low keeps read value until new read or firmware write.
// - Write trigger needs store_permit set by an earlier register write.
// - Clearing store_permit mid-cycle does not abort the write.
// - unlock_port has no storage; it only feeds the unlock check.
// - Program read loads data high:low after the second following cycle.
// - Power-up clears store_permit.
`ifndef NVM_CTRL_MAP_VH
`define NVM_CTRL_MAP_VH
`define ADDR_DATA_LOW 9'h10c
`define ADDR_ADDR_LOW 9'h10d
`define ADDR_DATA_HIGH 9'h10e
`define ADDR_ADDR_HIGH 9'h10f
`define ADDR_CONTROL 9'h18c
`define ADDR_UNLOCK 9'h18d
`define BIT_SPACE 7
`define BIT_ERR 3
`define BIT_PERMIT 2
`define BIT_WR 1
`define BIT_RD 0
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'haa
`define CONTROL_USED_MASK 8'h8f
`define PROG_READ_CYCLES 2'h2
`endif

// ==== rtl/nvm_read_write_controller.v ====
// NVM read/write controller: control register, unlock check and storage-array sequencing.
// Assumes the core's register bus on clk and a storage array with request/done handshake.
`timescale 1ns/1ps
`include "nvm_ctrl_map.vh"
module nvm_read_write_controller (
    // Clock and resets.
    input wire clk,
    input wire rst,
    input wire soft_reset,
    // Core register bus.
    input wire [8:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Core stall and completion event.
    output wire core_stall,
    output reg store_done_flag_set,
    // Storage array side.
    output reg arr_rd_req,
    output reg arr_wr_req,
    output reg arr_space,
    output reg [12:0] arr_addr,
    output reg [13:0] arr_wdata,
    input wire [13:0] arr_rdata,
    input wire arr_wr_done
);
    localparam S_IDLE = 3'b001;
    localparam S_PREAD = 3'b010;
    localparam S_WRITE = 3'b100;

    // Sequencer state.
    reg [2:0] state_r;
    reg [1:0] rd_cnt_r;

    // Control register bits.
    reg space_select_r;
    reg aborted_store_flag_r;
    reg store_permit_r;
    reg wr_r;
    reg rd_r;

    // Address and data holding registers.
    reg [7:0] nvm_addr_low_r;
    reg [4:0] nvm_addr_high_r;
    reg [7:0] nvm_data_low_r;
    reg [5:0] nvm_data_high_r;

    // Unlock progress: bit 0 saw the first value, bit 1 saw the pair in order.
    reg [1:0] unlock_r;

    // Decodes and status shared by the processes below.
    wire ctl_wr = reg_wr && (reg_addr == `ADDR_CONTROL);
    wire busy = (state_r != S_IDLE);
    wire unlocked = unlock_r[1];
    // Trigger needs permit already stored, not the one in this same write.
    wire wr_start = ctl_wr && reg_wdata[`BIT_WR] && store_permit_r && unlocked
        && !busy;
    wire rd_start = ctl_wr && reg_wdata[`BIT_RD] && !busy && !wr_start;
    wire [7:0] control_view = {space_select_r, 3'b000, aborted_store_flag_r,
        store_permit_r, wr_r, rd_r};

    // Values that select and address take at this edge. The idle array address follows them,
    // so a data read in the very next cycle already sees the byte just pointed at.
    wire addr_low_wr = reg_wr && (reg_addr == `ADDR_ADDR_LOW);
    wire addr_high_wr = reg_wr && (reg_addr == `ADDR_ADDR_HIGH);
    wire space_nxt = (ctl_wr && !busy) ? reg_wdata[`BIT_SPACE] : space_select_r;
    wire [7:0] addr_low_nxt = addr_low_wr ? reg_wdata : nvm_addr_low_r;
    wire [4:0] addr_high_nxt = addr_high_wr ? reg_wdata[4:0] : nvm_addr_high_r;
    wire [12:0] addr_nxt = space_nxt ? {addr_high_nxt, addr_low_nxt}
        : {5'h00, addr_low_nxt};

    // Program writes halt the core until the array reports done.
    assign core_stall = (state_r == S_WRITE) && space_select_r;

    // Unlock check: two-stage record, no storage of the values themselves.
    always @(posedge clk) begin
        if (rst || soft_reset) begin
            unlock_r <= 2'b00;
        end else if (reg_wr && reg_addr == `ADDR_UNLOCK) begin
            unlock_r[0] <= (reg_wdata == `UNLOCK_FIRST);
            unlock_r[1] <= unlock_r[0] && (reg_wdata == `UNLOCK_SECOND);
        end else if (reg_wr || (reg_rd && reg_addr == `ADDR_UNLOCK)) begin
            // Any other register write, or a read of the port, restarts the check.
            unlock_r <= 2'b00;
        end
    end

    // Address, data and select survive soft resets; only power-on clears them.
    always @(posedge clk) begin
        if (rst) begin
            space_select_r <= 1'b0;
            nvm_addr_low_r <= 8'h00;
            nvm_addr_high_r <= 5'h00;
            nvm_data_low_r <= 8'h00;
            nvm_data_high_r <= 6'h00;
        end else begin
            if (soft_reset) begin
                space_select_r <= space_select_r;
            end else if (ctl_wr && !busy) begin
                space_select_r <= reg_wdata[`BIT_SPACE];
            end
            // Firmware loads of address and data; soft resets leave them alone.
            if (!soft_reset && reg_wr && reg_addr == `ADDR_ADDR_LOW) begin
                nvm_addr_low_r <= reg_wdata;
            end
            if (!soft_reset && reg_wr && reg_addr == `ADDR_ADDR_HIGH) begin
                nvm_addr_high_r <= reg_wdata[4:0];
            end
            // Read data wins over a same-cycle firmware store to the low byte; a store to the high byte wins.
            if (!soft_reset && rd_start && !reg_wdata[`BIT_SPACE] && !space_select_r) begin
                nvm_data_low_r <= arr_rdata[7:0];
            end else if (!soft_reset && state_r == S_PREAD && rd_cnt_r == 2'd1) begin
                nvm_data_low_r <= arr_rdata[7:0];
                nvm_data_high_r <= arr_rdata[13:8];
            end else if (!soft_reset && reg_wr && reg_addr == `ADDR_DATA_LOW) begin
                nvm_data_low_r <= reg_wdata;
            end
            if (!soft_reset && reg_wr && reg_addr == `ADDR_DATA_HIGH) begin
                nvm_data_high_r <= reg_wdata[5:0];
            end
        end
    end

    // Sequencer and control bits.
    always @(posedge clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            rd_cnt_r <= 2'd0;
            store_permit_r <= 1'b0;
            aborted_store_flag_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            store_done_flag_set <= 1'b0;
            arr_rd_req <= 1'b0;
            arr_wr_req <= 1'b0;
            arr_space <= 1'b0;
            arr_addr <= 13'h0000;
            arr_wdata <= 14'h0000;
        end else if (soft_reset) begin
            // A write cut short by an external or watchdog reset is reported.
            // Array address and space are kept, like the registers they mirror.
            if (state_r == S_WRITE) begin
                aborted_store_flag_r <= 1'b1;
            end
            state_r <= S_IDLE;
            store_permit_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            store_done_flag_set <= 1'b0;
            arr_rd_req <= 1'b0;
            arr_wr_req <= 1'b0;
        end else begin
            // Pulses last one cycle unless raised again below.
            store_done_flag_set <= 1'b0;
            arr_rd_req <= 1'b0;
            if (ctl_wr) begin
                // Permit may drop mid-write without stopping the cycle.
                store_permit_r <= reg_wdata[`BIT_PERMIT];
                aborted_store_flag_r <= reg_wdata[`BIT_ERR];
            end
            case (state_r)
                // Idle: a write trigger outranks a read trigger in the same write.
                S_IDLE: begin
                    if (wr_start) begin
                        state_r <= S_WRITE;
                        wr_r <= 1'b1;
                        arr_wr_req <= 1'b1;
                        arr_space <= space_select_r;
                        arr_addr <= space_select_r ? {nvm_addr_high_r, nvm_addr_low_r}
                            : {5'h00, nvm_addr_low_r};
                        arr_wdata <= space_select_r ? {nvm_data_high_r, nvm_data_low_r}
                            : {6'h00, nvm_data_low_r};
                    end else if (rd_start && space_select_r) begin
                        state_r <= S_PREAD;
                        rd_r <= 1'b1;
                        rd_cnt_r <= `PROG_READ_CYCLES;
                        arr_rd_req <= 1'b1;
                        arr_space <= 1'b1;
                        arr_addr <= {nvm_addr_high_r, nvm_addr_low_r};
                    end else begin
                        // Track select and address so the array shows the current cell.
                        arr_space <= space_nxt;
                        arr_addr <= addr_nxt;
                    end
                end
                // Program read: count down the two cycles the array needs.
                S_PREAD: begin
                    rd_cnt_r <= rd_cnt_r - 2'd1;
                    if (rd_cnt_r == 2'd1) begin
                        state_r <= S_IDLE;
                        rd_r <= 1'b0;
                    end
                end
                // Write: hold the request until the array reports done.
                S_WRITE: begin
                    if (arr_wr_done) begin
                        state_r <= S_IDLE;
                        wr_r <= 1'b0;
                        arr_wr_req <= 1'b0;
                        store_done_flag_set <= 1'b1;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Register read mux; unlock port reads zero, unused control bits zero.
    always @* begin
        case (reg_addr)
            `ADDR_CONTROL: reg_rdata = control_view & `CONTROL_USED_MASK;
            `ADDR_ADDR_LOW: reg_rdata = nvm_addr_low_r;
            `ADDR_ADDR_HIGH: reg_rdata = {3'b000, nvm_addr_high_r};
            `ADDR_DATA_LOW: reg_rdata = nvm_data_low_r;
            `ADDR_DATA_HIGH: reg_rdata = {2'b00, nvm_data_high_r};
            default: reg_rdata = 8'h00;
        endcase
    end
endmodule // nvm_read_write_controller

// ==== sim/nvm_array_model.sv ====
// Behavioural storage arrays: one data-byte space and one program-word space.
// Assumes the controller holds request, space, address and data steady until done.
`timescale 1ns/1ps
module nvm_array_model (
    // Array port.
    input wire clk,
    input wire arr_wr_req,
    input wire arr_space,
    input wire [12:0] arr_addr,
    input wire [13:0] arr_wdata,
    output wire [13:0] arr_rdata,
    output reg arr_wr_done
);
    reg [13:0] prog [0:8191];
    reg [7:0] dmem [0:255];
    integer cnt = 0;
    integer lat = 3;
    // Reads are combinational; unwritten cells stay unknown so stale reads show up.
    assign arr_rdata = arr_space ? prog[arr_addr] : {6'h00, dmem[arr_addr[7:0]]};
    // A write is stored and acknowledged lat+1 cycles after the request rises.
    always @(posedge clk) begin
        arr_wr_done <= 1'b0;
        cnt <= (arr_wr_req && !arr_wr_done) ? cnt + 1 : 0;
        if (arr_wr_req && cnt == lat) begin
            arr_wr_done <= 1'b1;
            if (arr_space) prog[arr_addr] <= arr_wdata;
            else dmem[arr_addr[7:0]] <= arr_wdata[7:0];
        end
    end
endmodule // nvm_array_model

// ==== sim/nvm_ctrl_monitor.sv ====
// Port checker for the NVM controller; shadows stored permit and unlock progress.
// Assumes it is bound to the controller and sees its ports only.
`timescale 1ns/1ps
`include "nvm_ctrl_map.vh"
module nvm_ctrl_monitor (
    // Clock and resets.
    input wire clk,
    input wire rst,
    input wire soft_reset,
    // Register bus.
    input wire [8:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Core and array side.
    input wire core_stall,
    input wire store_done_flag_set,
    input wire arr_rd_req,
    input wire arr_wr_req,
    input wire arr_space,
    input wire [12:0] arr_addr,
    input wire [13:0] arr_wdata,
    input wire [13:0] arr_rdata,
    input wire arr_wr_done
);
    reg [1:0] unl_r;
    reg perm_r;
    wire ctl_w = reg_wr && reg_addr == `ADDR_CONTROL;
    wire unl_ok = ctl_w && reg_wdata[`BIT_WR] && unl_r == 2'd2;
    // Any bus write other than the next unlock value, or a port read, restarts the shadow.
    always @(posedge clk) begin
        if (rst || soft_reset) begin
            unl_r <= 2'd0;
            perm_r <= 1'b0;
        end else if (reg_wr) begin
            unl_r <= (reg_addr != `ADDR_UNLOCK) ? 2'd0 : (reg_wdata == `UNLOCK_FIRST) ? 2'd1 :
                (unl_r == 2'd1 && reg_wdata == `UNLOCK_SECOND) ? 2'd2 : 2'd0;
            if (ctl_w) perm_r <= reg_wdata[`BIT_PERMIT];
        end else if (reg_rd && reg_addr == `ADDR_UNLOCK) begin
            unl_r <= 2'd0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || soft_reset);
    start_needs_unlock_a: assert property ($rose(arr_wr_req) |-> $past(unl_ok))
        else $error("write began without the unlock pair");
    start_needs_permit_a: assert property ($rose(arr_wr_req) |-> $past(perm_r))
        else $error("write began without a stored permit");
    done_ends_write_a: assert property (arr_wr_req && arr_wr_done
        |=> store_done_flag_set && !arr_wr_req)
        else $error("write did not finish after array done");
    flag_has_cause_a: assert property (store_done_flag_set |-> $past(arr_wr_done))
        else $error("done flag without array done");
    write_holds_a: assert property (arr_wr_req && !arr_wr_done |=> arr_wr_req)
        else $error("write request dropped early");
    stall_for_prog_a: assert property ($rose(arr_wr_req) |-> core_stall == arr_space)
        else $error("core stall does not match space");
    payload_steady_a: assert property (arr_wr_req && $past(arr_wr_req)
        |-> $stable(arr_addr) && $stable(arr_wdata) && $stable(arr_space))
        else $error("write payload moved mid-cycle");
    prog_read_only_a: assert property (arr_rd_req |-> arr_space)
        else $error("array read request in data space");
    spare_bits_zero_a: assert property (reg_addr == `ADDR_CONTROL
        |-> reg_rdata[6:4] == 3'd0)
        else $error("unused control bits read nonzero");
    cover property ($rose(arr_wr_req) && !arr_space);
    cover property ($rose(arr_wr_req) && arr_space);
    cover property (arr_rd_req);
endmodule // nvm_ctrl_monitor
bind nvm_read_write_controller nvm_ctrl_monitor mon (.clk(clk), .rst(rst), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .core_stall(core_stall), .store_done_flag_set(store_done_flag_set),
    .arr_rd_req(arr_rd_req), .arr_wr_req(arr_wr_req), .arr_space(arr_space),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_wr_done(arr_wr_done));

// ==== sim/testbench.sv ====
// Register-level tests of the NVM controller against the array model.
// Assumes controller, map header, model and monitor are compiled first.
`timescale 1ns/1ps
`include "nvm_ctrl_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    reg clk = 0, rst = 1, soft_reset = 0, reg_wr = 0, reg_rd = 0;
    reg [8:0] reg_addr = 9'h000;
    reg [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire [13:0] arr_wdata, arr_rdata;
    wire [12:0] arr_addr;
    wire core_stall, done_set, arr_rd_req, arr_wr_req, arr_space, arr_wr_done;
    integer err_count = 0, tests_run = 0, dones = 0;
    localparam [8:0] C = `ADDR_CONTROL, U = `ADDR_UNLOCK;
    nvm_read_write_controller uut (.clk(clk), .rst(rst), .soft_reset(soft_reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .core_stall(core_stall), .store_done_flag_set(done_set),
        .arr_rd_req(arr_rd_req), .arr_wr_req(arr_wr_req), .arr_space(arr_space),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
        .arr_wr_done(arr_wr_done));
    nvm_array_model mdl (.clk(clk), .arr_wr_req(arr_wr_req), .arr_space(arr_space),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
        .arr_wr_done(arr_wr_done));
    // Clock, and a count of completion pulses so a missing or doubled one is seen.
    // Counting at the falling edge lets a check made just after a poll see the last pulse.
    always #5 clk = ~clk;
    always @(negedge clk) if (done_set) dones <= dones + 1;
    // One bus cycle: set up at a falling edge, taken at the next rising edge.
    task put(input [8:0] a, input [7:0] d, input w);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = w;
            reg_rd = !w;
        end
    endtask
    task rd(input [8:0] a, input [7:0] e);
        begin
            put(a, 8'h00, 1'b0);
            #1 `CHK(reg_rdata, e)
        end
    endtask
    // Permit, unlock pair, then trigger; s carries the space select.
    task launch(input [7:0] s);
        begin
            put(C, s | 8'h04, 1'b1);
            put(U, `UNLOCK_FIRST, 1'b1);
            put(U, `UNLOCK_SECOND, 1'b1);
            put(C, s | 8'h06, 1'b1);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Polls the trigger bit under a bound; running out is a mismatch.
    task wait_wr;
        integer i;
        begin
            i = 0;
            do begin put(C, 8'h00, 1'b0); #1 i = i + 1; end
            while (reg_rdata[`BIT_WR] !== 1'b0 && i < 99);
            if (i >= 99) begin err_count++; close_out; end
        end
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        rd(C, 8'h00);
        put(C, 8'h70, 1'b1);
        rd(C, 8'h00);
        $display("test reset_and_spare done");
        put(`ADDR_ADDR_LOW, 8'h05, 1'b1);
        put(`ADDR_DATA_LOW, 8'h3c, 1'b1);
        put(U, 8'h55, 1'b1);
        put(U, 8'haa, 1'b1);
        put(C, 8'h06, 1'b1);
        rd(C, 8'h04);
        put(U, 8'h55, 1'b1);
        put(`ADDR_ADDR_HIGH, 8'h00, 1'b1);
        put(U, 8'haa, 1'b1);
        put(C, 8'h06, 1'b1);
        rd(C, 8'h04);
        put(U, `UNLOCK_FIRST, 1'b1);
        put(U, `UNLOCK_SECOND, 1'b1);
        rd(U, 8'h00);
        put(C, 8'h06, 1'b1);
        rd(C, 8'h04);
        $display("test refused_writes done");
        launch(8'h00);
        rd(C, 8'h06);
        `CHK(core_stall, 1'b0)
        put(C, 8'h80, 1'b1);
        rd(C, 8'h02);
        wait_wr;
        `CHK(dones, 1)
        put(`ADDR_DATA_LOW, 8'h00, 1'b1);
        put(C, 8'h01, 1'b1);
        rd(`ADDR_DATA_LOW, 8'h3c);
        put(`ADDR_ADDR_LOW, 8'h06, 1'b1);
        rd(`ADDR_DATA_LOW, 8'h3c);
        $display("test data_write_read done");
        put(`ADDR_ADDR_HIGH, 8'h01, 1'b1);
        put(`ADDR_ADDR_LOW, 8'h23, 1'b1);
        put(`ADDR_DATA_HIGH, 8'h2a, 1'b1);
        put(`ADDR_DATA_LOW, 8'h5b, 1'b1);
        put(C, 8'h80, 1'b1);
        launch(8'h80);
        rd(C, 8'h86);
        `CHK(core_stall, 1'b1)
        wait_wr;
        `CHK(dones, 2)
        put(`ADDR_DATA_LOW, 8'h00, 1'b1);
        put(`ADDR_DATA_HIGH, 8'h00, 1'b1);
        put(C, 8'h81, 1'b1);
        rd(C, 8'h81);
        rd(C, 8'h81);
        rd(`ADDR_DATA_LOW, 8'h5b);
        rd(`ADDR_DATA_HIGH, 8'h2a);
        rd(C, 8'h80);
        $display("test program_write_read done");
        mdl.lat = 30;
        put(C, 8'h00, 1'b1);
        put(`ADDR_ADDR_LOW, 8'h07, 1'b1);
        launch(8'h00);
        rd(C, 8'h06);
        soft_reset = 1;
        @(negedge clk);
        soft_reset = 0;
        rd(C, 8'h08);
        rd(`ADDR_ADDR_LOW, 8'h07);
        `CHK(dones, 2)
        $display("test aborted_write done");
        close_out;
    end
endmodule // testbench
